// >>> verilog/pdc_channel.sv
`timescale 1ns/1ps
module pdc_channel
  import pdc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             reset,
  // Peripheral side
  input  wire pdc_config_type   cfg,
  input  wire logic             start,
  input  wire logic             stop,
  input  wire logic [7:0]       wr_data,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  output logic [7:0]            rd_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic                  busy,
  output logic                  end_pulse,
  output logic                  range_error,
  output logic [15:0]           transferred_byte_count,
  output logic                  dropped,
  // AHB master
  output logic [31:0]           haddr,
  output logic [1:0]            htrans,
  output logic                  hwrite,
  output logic [2:0]            hsize,
  output logic [31:0]           hwdata,
  output logic                  hbusreq,
  input  wire logic             hgrant,
  input  wire logic             hready,
  input  wire logic [1:0]       hresp,
  input  wire logic [31:0]      hrdata
);
  // ==========================================================
  // Behaviour
  // - Channel is an AHB master to RAM
  // - Addresses outside RAM are never issued
  // - Each instance has own pointer, count, transferred_byte_count
  // - Reader fetches bytes up to max count
  // - Ram_write_channel stores at most max count bytes
  // - Transferred_byte_count shows bytes actually moved
  // - Invalid pointer flagged, no safe fallback
  // - Contention stalls; drop_on_stall only sets dropped on writes, the byte is kept
  // - Arbiter grant honoured, waits while not granted

  // ==========================================================
  // Transfer state
  pdc_state_type  state;
  pdc_config_type active;
  logic [31:0]    addr;
  logic [15:0]    remaining;
  logic [15:0]    moved;
  logic [7:0]     byte_out;
  logic           in_range;
  logic           rfifo_in_ready;
  logic           rfifo_push;
  logic [7:0]     lane_byte;
  logic           wfifo_valid;
  logic [7:0]     wfifo_data;
  logic           wfifo_pop;
  logic           have_byte;
  logic           issue;
  logic           addr_phase;
  logic           rfifo_out_valid;
  logic [7:0]     rfifo_out_data;
  logic           rfifo_pop;

  // Bytes past the RAM top are refused before any bus cycle
  assign in_range = (addr >= RAM_BASE) && (addr < RAM_BASE + RAM_SIZE);
  assign lane_byte = 8'(hrdata >> ({3'h0, addr[1:0] & BYTE_LANE_MASK} << LANE_SHIFT));
  assign have_byte = active.write_dir ? wfifo_valid : rfifo_in_ready;
  // One byte in flight: data is taken only once the address phase is accepted
  assign issue      = (state == PDC_ADDR) && !stop && (remaining != COUNT_ZERO) && in_range
                      && hgrant && hready && have_byte;
  assign rfifo_push = (state == PDC_DATA) && !addr_phase && hready && !active.write_dir;
  assign wfifo_pop  = issue && active.write_dir;
  assign rfifo_pop  = rfifo_out_valid && (!rd_valid || rd_ready);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state       <= PDC_IDLE;
      active      <= '0;
      addr        <= '0;
      remaining   <= COUNT_ZERO;
      moved       <= COUNT_ZERO;
      range_error <= 1'b0;
      dropped     <= 1'b0;
      byte_out    <= 8'h00;
    end else begin
      unique case (state)
        PDC_IDLE: begin
          if (start) begin
            active      <= cfg;
            addr        <= cfg.start_pointer;
            remaining   <= cfg.max_byte_count;
            moved       <= COUNT_ZERO;
            range_error <= 1'b0;
            dropped     <= 1'b0;
            state       <= PDC_ADDR;
          end
        end
        PDC_ADDR: begin
          if (stop || remaining == COUNT_ZERO) begin
            state <= PDC_DONE;
          end else if (!in_range) begin
            range_error <= 1'b1;
            state       <= PDC_DONE;
          end else if (hgrant && hready && have_byte) begin
            byte_out <= wfifo_data;
            state    <= PDC_DATA;
          end else if (!hgrant && active.drop_on_stall && active.write_dir && wfifo_valid) begin
            dropped <= 1'b1;
          end
        end
        PDC_DATA: begin
          if (hready && !addr_phase) begin
            addr      <= addr + ADDR_ONE;
            remaining <= remaining - COUNT_ONE;
            if (hresp == HRESP_OKAY) begin
              moved <= moved + COUNT_ONE;
            end else begin
              range_error <= 1'b1;
            end
            state <= PDC_ADDR;
          end
        end
        PDC_DONE: begin
          state <= PDC_IDLE;
        end
        default: state <= PDC_IDLE;
      endcase
    end
  end

  // ==========================================================
  // AHB address and data phase, registered outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      haddr   <= '0;
      htrans  <= HTRANS_IDLE;
      hwrite  <= 1'b0;
      hsize   <= HSIZE_BYTE;
      hbusreq <= 1'b0;
      hwdata  <= '0;
    end else begin
      hbusreq <= (state == PDC_ADDR) && in_range && remaining != COUNT_ZERO && have_byte;
      if (issue) begin
        haddr  <= addr;
        htrans <= HTRANS_NONSEQ;
        hwrite <= active.write_dir;
        hsize  <= HSIZE_BYTE;
      end else if (hready) begin
        htrans <= HTRANS_IDLE;
      end
      if (state == PDC_DATA) begin
        hwdata <= {4{byte_out}}; // Byte replicated so any lane is right
      end
    end
  end

  // ==========================================================
  // Address phase flag, cleared when the slave takes the address
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      addr_phase <= 1'b0;
    end else if (issue) begin
      addr_phase <= 1'b1;
    end else if (hready) begin
      addr_phase <= 1'b0;
    end
  end

  // ==========================================================
  // Read byte register, so the peripheral sees flop outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_valid <= 1'b0;
      rd_data  <= 8'h00;
    end else if (start && state == PDC_IDLE) begin
      rd_valid <= 1'b0;
    end else if (rfifo_pop) begin
      rd_valid <= 1'b1;
      rd_data  <= rfifo_out_data;
    end else if (rd_ready) begin
      rd_valid <= 1'b0;
    end
  end

  // ==========================================================
  // Status outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      end_pulse              <= 1'b0;
      busy                   <= 1'b0;
      transferred_byte_count <= COUNT_ZERO;
    end else begin
      end_pulse <= (state == PDC_DONE);
      busy      <= (state != PDC_IDLE) || start;
      if (state == PDC_DONE) begin
        transferred_byte_count <= moved;
      end
    end
  end

  // Read data buffered toward the peripheral; full buffer stalls the bus
  pdc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_read_fifo (
    .clk       (clk),
    .reset     (reset),
    .flush     (start && state == PDC_IDLE),
    .in_data   (lane_byte),
    .in_valid  (rfifo_push),
    .in_ready  (rfifo_in_ready),
    .out_data  (rfifo_out_data),
    .out_valid (rfifo_out_valid),
    .out_ready (rfifo_pop)
  );

  // Write data from the peripheral; ready drops when full
  pdc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_write_fifo (
    .clk       (clk),
    .reset     (reset),
    .flush     (1'b0),
    .in_data   (wr_data),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .out_data  (wfifo_data),
    .out_valid (wfifo_valid),
    .out_ready (wfifo_pop)
  );
endmodule

// >>> verilog/pdc_pkg.sv
package pdc_pkg;
  // ==========================================================
  // Widths and address map
  localparam int unsigned ADDR_WIDTH      = 32;
  localparam int unsigned COUNT_WIDTH     = 16;
  localparam logic [31:0] RAM_BASE        = 32'h2000_0000;
  localparam logic [31:0] RAM_SIZE        = 32'h0000_6000;
  // AHB encodings, count and address steps, lane and fifo constants
  localparam logic [1:0]  HTRANS_IDLE     = 2'h0;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic [2:0]  HSIZE_BYTE      = 3'h0;
  localparam logic [1:0]  HRESP_OKAY      = 2'h0;
  localparam logic [15:0] COUNT_ZERO      = 16'h0000;
  localparam logic [15:0] COUNT_ONE       = 16'h0001;
  localparam logic [31:0] ADDR_ONE        = 32'h0000_0001;
  localparam logic [1:0]  BYTE_LANE_MASK  = 2'h3;
  localparam int unsigned LANE_SHIFT      = 3;
  localparam int unsigned FIFO_DEPTH      = 4;

  // ==========================================================
  // Channel configuration carried as one bundle
  typedef struct packed {
    logic [31:0] start_pointer;
    logic [15:0] max_byte_count;
    logic        write_dir;
    logic        drop_on_stall;
  } pdc_config_type;

  typedef enum logic [1:0] {
    PDC_IDLE = 2'b00,
    PDC_ADDR = 2'b01,
    PDC_DATA = 2'b11,
    PDC_DONE = 2'b10
  } pdc_state_type;
endpackage

// >>> verilog/pdc_fifo.sv
`timescale 1ns/1ps
module pdc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_index;
  logic [AW-1:0]    rd_index;
  logic [AW:0]      fill;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_index];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_index <= '0;
      rd_index <= '0;
      fill     <= '0;
    end else if (flush) begin
      wr_index <= '0;
      rd_index <= '0;
      fill     <= '0;
    end else begin
      if (push) begin
        wr_index <= (wr_index == AW'(DEPTH - 1)) ? '0 : wr_index + AW'(1);
      end
      if (pop) begin
        rd_index <= (rd_index == AW'(DEPTH - 1)) ? '0 : rd_index + AW'(1);
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_index] <= in_data;
    end
  end
endmodule

// >>> verif/pdc_channel_props.sv
`timescale 1ns/1ps
module pdc_channel_props
  import pdc_pkg::*;
(
  input wire logic           clk,
  input wire logic           reset,
  input wire pdc_config_type cfg,
  input wire logic           start,
  input wire logic           busy,
  input wire logic           end_pulse,
  input wire logic [15:0]    transferred_byte_count,
  input wire logic [31:0]    haddr,
  input wire logic [1:0]     htrans,
  input wire logic [2:0]     hsize,
  input wire logic           hgrant,
  input wire logic           hready
);
  // ==========================================================
  // Bus and completion checks
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire logic nseq = (htrans == HTRANS_NONSEQ);
  AST_BYTE: assert property (nseq |-> hsize == HSIZE_BYTE) else $error("size not byte");
  AST_RAM: assert property (nseq |-> haddr >= RAM_BASE && haddr < RAM_BASE + RAM_SIZE)
    else $error("address outside ram");
  AST_GAP: assert property (nseq && hready |=> !nseq) else $error("back to back transfer");
  AST_GRANT: assert property (nseq |-> $past(hgrant)) else $error("transfer without grant");
  AST_IDLE: assert property (!busy |-> htrans == HTRANS_IDLE) else $error("bus active when idle");
  AST_BUSY: assert property ($rose(busy) |-> $past(start)) else $error("busy without start");
  AST_END: assert property (end_pulse |=> !end_pulse) else $error("end pulse too long");
  AST_AMT: assert property ($changed(transferred_byte_count) |-> end_pulse) else $error("transferred_byte_count moved");
  AST_MAX: assert property (end_pulse |-> transferred_byte_count <= cfg.max_byte_count)
    else $error("transferred_byte_count above max");
endmodule
bind pdc_channel pdc_channel_props chk (.clk, .reset, .cfg, .start, .busy, .end_pulse,
  .transferred_byte_count, .haddr, .htrans, .hsize, .hgrant, .hready);

// >>> verif/pdc_ram_model.sv
`timescale 1ns/1ps
module pdc_ram_model
  import pdc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        stall,
  input  wire logic        slow,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hbusreq,
  output logic             hgrant,
  output logic             hready,
  output logic [1:0]       hresp,
  output logic [31:0]      hrdata
);
  // ==========================================================
  // Byte ram with one wait state when slow
  logic [7:0]  mem [0:63];
  logic        dph;
  logic        wr;
  logic        waited;
  logic [31:0] a;
  assign hgrant = hbusreq && !stall;
  assign hready = !(dph && slow && !waited);
  assign hresp  = HRESP_OKAY;
  // Outside a data phase the bus carries the inverted byte so stale data never looks valid
  assign hrdata = dph ? ({24'h0, mem[a[5:0]]} << (8 * a[1:0])) : ~{4{mem[a[5:0]]}};
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dph    <= 1'b0;
      wr     <= 1'b0;
      waited <= 1'b0;
      a      <= 32'h0;
    end else begin
      waited <= dph && !hready;
      if (hready) begin
        dph <= (htrans == HTRANS_NONSEQ);
        wr  <= hwrite;
        a   <= haddr;
      end
    end
  end
  // Plain always so the bench may preload the array
  always @(posedge clk) begin
    if (!reset && dph && hready && wr) begin
      mem[a[5:0]] <= hwdata[8 * a[1:0] +: 8];
    end
  end
endmodule

// >>> verif/peripheral_dma_channel_tb.sv
`timescale 1ns/1ps
module peripheral_dma_channel_tb
  import pdc_pkg::*;
;
  logic clk = 0, reset = 1, start = 0, stop = 0, wr_valid = 0, rd_ready = 0, stall = 0, slow = 0;
  logic hgrant, hready, wr_ready, rd_valid, busy, end_pulse, range_error, dropped, hwrite, hbusreq;
  logic [7:0] wr_data = 8'h0, rd_data;
  logic [15:0] amt;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  pdc_config_type cfg = '0;
  int miscompares = 0, checked = 0, cycles = 0;
  pdc_channel dut (.clk, .reset, .cfg, .start, .stop, .wr_data, .wr_valid, .wr_ready, .rd_data, .rd_valid,
    .rd_ready, .busy, .end_pulse, .range_error, .transferred_byte_count(amt), .dropped, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hbusreq, .hgrant, .hready, .hresp, .hrdata);
  pdc_ram_model ram (.clk, .reset, .stall, .slow, .haddr, .htrans, .hwrite, .hwdata, .hbusreq, .hgrant,
    .hready, .hresp, .hrdata);
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  // ==========================================================
  // Helpers
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic kick(logic [31:0] p, logic [15:0] n, logic w, logic d);
    @(posedge clk); #1;
    cfg = '{p, n, w, d};
    start = 1;
    @(posedge clk); #1;
    start = 0;
  endtask
  task automatic until_idle();
    repeat (400) begin
      @(posedge clk); #1;
      if (busy === 1'b0) break;
    end
  endtask
  task automatic wait_valid();
    for (int n = 0; n < 100 && rd_valid !== 1'b1; n++) begin
      @(posedge clk); #1;
    end
  endtask
  task automatic push(logic [7:0] b);
    wr_data = b;
    wr_valid = 1;
    for (int n = 0; n < 100; n++) begin
      @(posedge clk);
      if (wr_ready === 1'b1) break;
    end
    #1;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_read();
    slow = 1;
    kick(RAM_BASE + 32'h1, 16'h5, 1'b0, 1'b0);
    @(posedge clk); #1 start = 1; // Second start while busy must be ignored
    @(posedge clk); #1 start = 0;
    repeat (40) @(posedge clk); // Reader fifo fills; fifo and rd_data hold all five bytes, so the bus never stalls
    #1 rd_ready = 1;
    for (int i = 0; i < 5; i++) begin
      wait_valid();
      cmp("rd_data", 32'(8'(i + 1) ^ 8'ha5), 32'(rd_data));
      @(posedge clk); #1;
    end
    rd_ready = 0;
    until_idle();
    cmp("read transferred_byte_count", 32'h5, 32'(amt));
    slow = 0;
  endtask
  task automatic t_write();
    stall = 1;
    kick(RAM_BASE + 32'h5, 16'h6, 1'b1, 1'b1);
    for (int i = 0; i < 4; i++) push(8'hc0 + 8'(i));
    wr_valid = 0;
    #1 cmp("wr_ready full", 32'h0, 32'(wr_ready));
    cmp("dropped", 32'h1, 32'(dropped));
    stall = 0;
    for (int i = 4; i < 6; i++) push(8'hc0 + 8'(i));
    wr_valid = 0;
    until_idle();
    cmp("write transferred_byte_count", 32'h6, 32'(amt));
    for (int i = 0; i < 7; i++)
      cmp("ram", 32'(i < 6 ? 8'hc0 + 8'(i) : 8'(11) ^ 8'ha5), 32'(ram.mem[5 + i]));
  endtask
  task automatic t_stop();
    kick(RAM_BASE + 32'h20, 16'h4, 1'b1, 1'b0);
    @(posedge clk); #1 stop = 1;
    for (int n = 0; n < 20 && end_pulse !== 1'b1; n++) begin
      @(posedge clk); #1;
    end
    cmp("end_pulse", 32'h1, 32'(end_pulse));
    cmp("stop transferred_byte_count", 32'h0, 32'(amt));
    stop = 0;
    until_idle();
  endtask
  task automatic t_range();
    kick(32'h0000_0100, 16'h4, 1'b0, 1'b0);
    until_idle();
    cmp("range_error", 32'h1, 32'(range_error));
    cmp("range transferred_byte_count", 32'h0, 32'(amt));
  endtask
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 64; i++) ram.mem[i] = 8'(i) ^ 8'ha5;
    repeat (8) @(posedge clk);
    #1 reset = 0;
    t_read();
    t_write();
    t_stop();
    t_range();
    conclude();
  end
endmodule
